//--- common/srp_pkg.sv
`default_nettype none
package srp_pkg;

   // ------------------------------------------------------------
   // register indices and byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0]  IDX_INDIRECT_READ_PAGE    = 8'hD4;
   localparam logic [7:0]  IDX_INDIRECT_WRITE_PAGE   = 8'hD5;
   localparam logic [7:0]  IDX_FLASH_BANK_SELECT     = 8'hFA;
   localparam logic [7:0]  IDX_SYSTEM_STATUS_CONTROL = 8'hFE;
   localparam logic [11:0] ADDR_INDIRECT_READ_PAGE    = {2'h0, IDX_INDIRECT_READ_PAGE, 2'h0};
   localparam logic [11:0] ADDR_INDIRECT_WRITE_PAGE   = {2'h0, IDX_INDIRECT_WRITE_PAGE, 2'h0};
   localparam logic [11:0] ADDR_FLASH_BANK_SELECT     = {2'h0, IDX_FLASH_BANK_SELECT, 2'h0};
   localparam logic [11:0] ADDR_SYSTEM_STATUS_CONTROL = {2'h0, IDX_SYSTEM_STATUS_CONTROL, 2'h0};

   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam int          PAGE_W           = 3;
   localparam int          BANK_W           = 2;
   localparam int          BIT_REPEATED     = 7;
   localparam int          BIT_SLOW_OSC     = 4;
   localparam int          BIT_XTAL_WRITTEN = 3;
   localparam int          BIT_XTAL_PRESENT = 2;
   localparam int          BIT_RAMCLR_DIS   = 0;
   localparam logic [2:0]  RST_PAGE         = 3'h0;
   localparam logic [1:0]  RST_BANK         = 2'h0;
   localparam logic        RST_BIT          = 1'b0;

   // ------------------------------------------------------------
   // oscillator and flash figures
   // ------------------------------------------------------------
   localparam int          IMO_FAST_MHZ     = 24;
   localparam int          IMO_SLOW_MHZ     = 6;
   localparam int          BANK0_USER_BYTES = 8192;
   localparam int          BANK_OFS_W       = $clog2(BANK0_USER_BYTES);
   localparam logic [1:0]  BOOT_PASS_ONE    = 2'h1;
   localparam logic [1:0]  BOOT_PASS_MANY   = 2'h2;

   // indirect-move access from the core
   typedef struct packed {
      logic rd;          // data phase of load-accumulator move
      logic wr;          // data phase of store-accumulator move
      logic ptr;         // pointer byte fetch of either move
   } srp_mvi_s;

   // system status and control fields
   typedef struct packed {
      logic repeated_boot_flag;
      logic slow_oscillator_select;
      logic crystal_flag_written;
      logic crystal_present_flag;
      logic watchdog_ram_clear_disable;
   } srp_scr_s;

endpackage
`default_nettype wire

//--- hdl/srp_regs.sv
`timescale 1ns/10ps
`default_nettype none
module srp_regs
   import srp_pkg::*;
#(
   parameter int SRAM_PAGES  = 8,
   parameter int FLASH_BANKS = 4
) (
   input  wire logic                  sys_clk,          // 25 MHz core clock
   input  wire logic                  rst_b,            // power-on or external reset
   input  wire logic                  psel,             // apb select
   input  wire logic                  penable,          // apb access phase
   input  wire logic                  pwrite,           // apb direction
   input  wire logic [11:0]           paddr,            // apb byte address
   input  wire logic [31:0]           pwdata,           // apb write data
   input  wire logic [3:0]            pstrb,            // apb byte strobes
   output logic                       pready,           // apb ready
   output logic [31:0]                prdata,           // apb read data
   output logic                       pslverr,          // apb error, unmapped
   input  wire srp_mvi_s              indirect_move_instruction,              // indirect-move phase
   input  wire logic [PAGE_W-1:0]     cur_page,         // current page pointer
   output logic [PAGE_W-1:0]          sram_page,        // page for this access
   input  wire logic                  boot_pass,        // boot routine started
   input  wire logic                  boot_done,        // boot routine finished
   input  wire logic                  supply_ok_pin,    // supply monitor, async
   input  wire logic                  flash_ready_pin,  // flash idle, async
   output logic                       user_exec_en,     // user flash may run
   input  wire logic                  ext_clock_pin,    // external clock mode, async
   output logic                       imo_slow,         // main oscillator at 6 MHz
   output logic                       system_clock_slow,      // system clock follows it, except in external clock mode
   input  wire logic                  xtal_switch_req,  // firmware asks for crystal
   output logic                       slow_clk_xtal,    // slow clock on crystal
   output logic                       ram_clear_min,    // minimum clear on watchdog
   input  wire logic [BANK_OFS_W-1:0] flash_ofs,        // boot-rom flash offset
   output logic [BANK_W+BANK_OFS_W-1:0] flash_addr,     // banked flash address
   output logic                       cal_table_bank    // access hits bank zero
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, ADDR_INDIRECT_READ_PAGE) | hit(a, ADDR_INDIRECT_WRITE_PAGE)
             | hit(a, ADDR_FLASH_BANK_SELECT) | hit(a, ADDR_SYSTEM_STATUS_CONTROL);
   endfunction

   localparam logic MULTI_PAGE = (SRAM_PAGES > 1);
   localparam logic MULTI_BANK = (FLASH_BANKS > 1);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] pins_in;

   assign pins_in = {supply_ok_pin, flash_ready_pin, ext_clock_pin};

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= pins_in;
         sync_b <= sync_a;
      end
   end

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   logic        next_pready;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        wr_now;
   logic [7:0]  rd_byte;

   // one wait state so that every answer leaves a flip-flop
   // a write lands only at the edge where the master sees pready high
   assign wr_now = psel & penable & pready & pwrite & pstrb[0] & mapped(paddr);

   always_comb begin
      next_pready  = psel & penable & ~pready;
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (psel & penable & ~pready) begin
         next_pslverr = ~mapped(paddr);
         if (!pwrite) begin
            next_prdata = {24'h00_0000, rd_byte};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= next_pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ------------------------------------------------------------
   // write strobes
   // ------------------------------------------------------------
   // one strobe per register keeps the bank logic free of address compares
   logic wr_rd_page;
   logic wr_wr_page;
   logic wr_bank;
   logic wr_scr;

   assign wr_rd_page = wr_now & hit(paddr, ADDR_INDIRECT_READ_PAGE);
   assign wr_wr_page = wr_now & hit(paddr, ADDR_INDIRECT_WRITE_PAGE);
   assign wr_bank    = wr_now & hit(paddr, ADDR_FLASH_BANK_SELECT);
   // the whole 12-bit address is decoded here: the two top bits must be zero
   assign wr_scr     = wr_now & hit(paddr, ADDR_SYSTEM_STATUS_CONTROL);

   // ------------------------------------------------------------
   // boot pass counting
   // ------------------------------------------------------------
   // saturates at two passes; only a fresh reset clears it
   logic [1:0] boot_count;
   logic [1:0] next_boot_count;

   always_comb begin
      next_boot_count = boot_count;
      if (boot_pass && boot_count != BOOT_PASS_MANY) begin
         next_boot_count = boot_count + 2'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         boot_count <= 2'h0;
      end else begin
         boot_count <= next_boot_count;
      end
   end

   // ------------------------------------------------------------
   // register bank
   // ------------------------------------------------------------
   logic [PAGE_W-1:0] indirect_read_page;
   logic [PAGE_W-1:0] indirect_write_page;
   logic [BANK_W-1:0] flash_bank_select;
   srp_scr_s          scr;
   logic [PAGE_W-1:0] next_rd_page;
   logic [PAGE_W-1:0] next_wr_page;
   logic [BANK_W-1:0] next_bank;
   srp_scr_s          next_scr;

   always_comb begin
      next_rd_page    = indirect_read_page;
      next_wr_page    = indirect_write_page;
      next_bank       = flash_bank_select;
      next_scr        = scr;
      next_scr.repeated_boot_flag = (next_boot_count == BOOT_PASS_MANY);
      if (wr_rd_page) begin
         next_rd_page = pwdata[PAGE_W-1:0];
      end
      if (wr_wr_page) begin
         next_wr_page = pwdata[PAGE_W-1:0];
      end
      if (wr_bank) begin
         next_bank = pwdata[BANK_W-1:0];
      end
      if (wr_scr) begin
         next_scr.slow_oscillator_select     = pwdata[BIT_SLOW_OSC];
         next_scr.watchdog_ram_clear_disable = pwdata[BIT_RAMCLR_DIS];
         // the lock is one-shot: a later write cannot undo a wrong claim
         if (!scr.crystal_flag_written) begin
            next_scr.crystal_present_flag = pwdata[BIT_XTAL_PRESENT];
            next_scr.crystal_flag_written = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         indirect_read_page  <= RST_PAGE;
         indirect_write_page <= RST_PAGE;
         flash_bank_select   <= RST_BANK;
         scr                 <= '{default: RST_BIT};
      end else begin
         indirect_read_page  <= next_rd_page;
         indirect_write_page <= next_wr_page;
         flash_bank_select   <= next_bank;
         scr                 <= next_scr;
      end
   end

   // reserved positions are built as constant zero
   always_comb begin
      rd_byte = 8'h00;
      if (hit(paddr, ADDR_INDIRECT_READ_PAGE)) begin
         rd_byte[PAGE_W-1:0] = indirect_read_page;
      end else if (hit(paddr, ADDR_INDIRECT_WRITE_PAGE)) begin
         rd_byte[PAGE_W-1:0] = indirect_write_page;
      end else if (hit(paddr, ADDR_FLASH_BANK_SELECT)) begin
         rd_byte[BANK_W-1:0] = flash_bank_select;
      end else if (hit(paddr, ADDR_SYSTEM_STATUS_CONTROL)) begin
         rd_byte[BIT_REPEATED]     = scr.repeated_boot_flag;
         rd_byte[BIT_SLOW_OSC]     = scr.slow_oscillator_select;
         rd_byte[BIT_XTAL_WRITTEN] = scr.crystal_flag_written;
         rd_byte[BIT_XTAL_PRESENT] = scr.crystal_present_flag;
         rd_byte[BIT_RAMCLR_DIS]   = scr.watchdog_ram_clear_disable;
      end
   end

   // ------------------------------------------------------------
   // indirect-move page steering
   // ------------------------------------------------------------
   // paging mode flags are deliberately not an input of this logic
   logic [PAGE_W-1:0] next_sram_page;

   always_comb begin
      next_sram_page = cur_page;
      if (indirect_move_instruction.ptr) begin
         next_sram_page = cur_page;
      end else if (indirect_move_instruction.rd) begin
         next_sram_page = indirect_read_page;
      end else if (indirect_move_instruction.wr) begin
         next_sram_page = indirect_write_page;
      end
      if (!MULTI_PAGE) begin
         next_sram_page = RST_PAGE;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sram_page <= RST_PAGE;
      end else begin
         sram_page <= next_sram_page;
      end
   end

   // ------------------------------------------------------------
   // boot hold, clocks and flash banking
   // ------------------------------------------------------------
   logic                         next_user_exec_en;
   logic                         next_imo_slow;
   logic                         next_system_clock_slow;
   logic                         next_slow_clk_xtal;
   logic                         next_ram_clear_min;
   logic                         next_cal_table_bank;
   logic [BANK_W+BANK_OFS_W-1:0] next_flash_addr;
   logic [BANK_W-1:0]            eff_bank;

   assign eff_bank = MULTI_BANK ? flash_bank_select : RST_BANK;

   always_comb begin
      // user code waits for a finished boot and both safety levels
      next_user_exec_en = boot_done & sync_b[2] & sync_b[1];
      next_imo_slow     = scr.slow_oscillator_select;
      next_system_clock_slow  = scr.slow_oscillator_select & ~sync_b[0];
      // a crystal never claimed stays locked out of the slow clock
      next_slow_clk_xtal = xtal_switch_req & scr.crystal_present_flag;
      next_flash_addr   = {eff_bank, flash_ofs};
      next_ram_clear_min  = scr.watchdog_ram_clear_disable;
      next_cal_table_bank = (eff_bank == RST_BANK);
   end

   // ------------------------------------------------------------
   // output registers
   // ------------------------------------------------------------
   // every top-level output leaves a flop, so outputs lag by one cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         user_exec_en   <= 1'b0;
         imo_slow       <= 1'b0;
         system_clock_slow    <= 1'b0;
         slow_clk_xtal  <= 1'b0;
         ram_clear_min  <= 1'b0;
         flash_addr     <= '0;
         cal_table_bank <= 1'b1;
      end else begin
         user_exec_en   <= next_user_exec_en;
         imo_slow       <= next_imo_slow;
         system_clock_slow    <= next_system_clock_slow;
         slow_clk_xtal  <= next_slow_clk_xtal;
         ram_clear_min  <= next_ram_clear_min;
         flash_addr     <= next_flash_addr;
         cal_table_bank <= next_cal_table_bank;
      end
   end

endmodule
`default_nettype wire

//--- bench/srp_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module srp_regs_sva
   import srp_pkg::*;
#(
   parameter int SRAM_PAGES = 8
) (
   input wire logic                        sys_clk,         // clock
   input wire logic                        rst_b,           // reset
   input wire logic                        psel,            // select
   input wire logic                        penable,         // access
   input wire logic                        pwrite,          // direction
   input wire logic [11:0]                 paddr,           // address
   input wire logic                        pready,          // ready
   input wire logic [31:0]                 prdata,          // read data
   input wire logic                        pslverr,         // error
   input wire srp_mvi_s                    indirect_move_instruction,             // move phase
   input wire logic [PAGE_W-1:0]           cur_page,        // current page
   input wire logic [PAGE_W-1:0]           sram_page,       // chosen page
   input wire logic                        boot_done,       // boot over
   input wire logic                        user_exec_en,    // user run
   input wire logic                        imo_slow,        // slow osc
   input wire logic                        system_clock_slow,     // slow clock
   input wire logic                        xtal_switch_req, // crystal ask
   input wire logic                        slow_clk_xtal,   // on crystal
   input wire logic [BANK_OFS_W-1:0]       flash_ofs,       // flash offset
   input wire logic [BANK_W+BANK_OFS_W-1:0] flash_addr,     // flash address
   input wire logic                        cal_table_bank   // bank zero
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   logic mapped;
   assign mapped = paddr inside {ADDR_INDIRECT_READ_PAGE, ADDR_INDIRECT_WRITE_PAGE,
                                 ADDR_FLASH_BANK_SELECT, ADDR_SYSTEM_STATUS_CONTROL};

   sequence s_wait;
      psel && penable && !pready;
   endsequence
   property p_answer; s_wait |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("pready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_unmapped; pready && !mapped && !pwrite |-> pslverr && prdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_mapped; pready && mapped |-> !pslverr && prdata[31:8] == 24'h0; endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access");
   property p_ptr; indirect_move_instruction.ptr |=> sram_page == (SRAM_PAGES > 1 ? $past(cur_page) : 3'h0); endproperty
   a_ptr: assert property (p_ptr) else $error("pointer page");
   property p_exec; user_exec_en |-> $past(boot_done); endproperty
   a_exec: assert property (p_exec) else $error("user run early");
   property p_xtal; slow_clk_xtal |-> $past(xtal_switch_req); endproperty
   a_xtal: assert property (p_xtal) else $error("crystal unasked");
   property p_sys; system_clock_slow |-> imo_slow; endproperty
   a_sys: assert property (p_sys) else $error("slow clock alone");
   property p_cal; cal_table_bank == (flash_addr[BANK_W+BANK_OFS_W-1 -: BANK_W] == 2'h0); endproperty
   a_cal: assert property (p_cal) else $error("bank zero flag");
   property p_ofs; rst_b |=> flash_addr[BANK_OFS_W-1:0] == $past(flash_ofs); endproperty
   a_ofs: assert property (p_ofs) else $error("flash offset");
endmodule
bind srp_regs srp_regs_sva #(.SRAM_PAGES(SRAM_PAGES)) sva_u (.*);
`default_nettype wire

//--- bench/srp_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module srp_core_model
   import srp_pkg::*;
(
   input  wire logic          sys_clk,   // core clock
   output srp_mvi_s           indirect_move_instruction,       // move phase
   output logic [PAGE_W-1:0]  cur_page,  // current page
   output logic               boot_pass, // boot pass pulse
   output logic               boot_done  // boot finished
);
   initial begin
      indirect_move_instruction       = '0;
      cur_page  = '0;
      boot_pass = 1'h0;
      boot_done = 1'h0;
   end
   // one phase per call, then idle; the page pointer is held between moves
   task automatic move(input srp_mvi_s m, input logic [PAGE_W-1:0] pg);
      @(posedge sys_clk);
      indirect_move_instruction      <= m;
      cur_page <= pg;
      @(posedge sys_clk);
      indirect_move_instruction      <= '0;
   endtask
   task automatic boot(input logic last);
      @(posedge sys_clk);
      boot_pass <= 1'h1;
      @(posedge sys_clk);
      boot_pass <= 1'h0;
      boot_done <= last;
   endtask
endmodule
`default_nettype wire

//--- bench/sram_page_and_system_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sram_page_and_system_control_regs_tb
   import srp_pkg::*;
();
   logic                        sys_clk = 1'h0;
   logic                        rst_b = 1'h0;
   logic                        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0]                 paddr = 12'h0;
   logic [31:0]                 pwdata = 32'h0;
   logic [3:0]                  pstrb = 4'h0;
   logic                        pready, pslverr, boot_pass, boot_done, user_exec_en;
   logic [31:0]                 prdata;
   srp_mvi_s                    indirect_move_instruction;
   logic [PAGE_W-1:0]           cur_page, sram_page;
   logic                        supply_ok_pin = 1'h0, flash_ready_pin = 1'h0;
   logic                        ext_clock_pin = 1'h0, xtal_switch_req = 1'h0;
   logic                        imo_slow, system_clock_slow, slow_clk_xtal, ram_clear_min;
   logic [BANK_OFS_W-1:0]       flash_ofs = 13'h0;
   logic [BANK_W+BANK_OFS_W-1:0] flash_addr;
   logic                        cal_table_bank;
   int                          error_cnt = 0, n_compared = 0;

   always #20 sys_clk = ~sys_clk;
   srp_regs dut_u (.*);
   srp_core_model core_u (.*);

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   // on a read, d is the expected data
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic xe);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      pstrb  <= 4'hF;
      @(posedge sys_clk);
      penable <= 1'h1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      chk("pready", 32'h1, 32'(pready));
      if (!w) chk("prdata", d, prdata);
      chk("pslverr", 32'(xe), 32'(pslverr));
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic do_reset();
      @(posedge sys_clk);
      rst_b <= 1'h0;
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'h1;
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      xfer(1'h0, ADDR_INDIRECT_READ_PAGE, 32'h0, 1'h0);
      xfer(1'h0, ADDR_INDIRECT_WRITE_PAGE, 32'h0, 1'h0);
      xfer(1'h0, ADDR_FLASH_BANK_SELECT, 32'h0, 1'h0);
      xfer(1'h0, ADDR_SYSTEM_STATUS_CONTROL, 32'h0, 1'h0);
      xfer(1'h1, 12'h3FC, 32'h7, 1'h1);
      xfer(1'h0, 12'h3FC, 32'h0, 1'h1);
      chk("cal_table_bank", 32'h1, 32'(cal_table_bank));
   endtask
   task automatic t_boot();
      core_u.boot(1'h0);
      xfer(1'h0, ADDR_SYSTEM_STATUS_CONTROL, 32'h0, 1'h0);
      core_u.boot(1'h1);
      xfer(1'h0, ADDR_SYSTEM_STATUS_CONTROL, 32'h80, 1'h0);
      repeat (5) @(negedge sys_clk);
      chk("user_exec_en", 32'h0, 32'(user_exec_en));
      @(posedge sys_clk);
      supply_ok_pin   <= 1'h1;
      flash_ready_pin <= 1'h1;
      repeat (5) @(negedge sys_clk);
      chk("user_exec_en", 32'h1, 32'(user_exec_en));
   endtask
   task automatic t_pages();
      logic [31:0] pg [3] = '{32'h2, 32'h3, 32'h5};
      xfer(1'h1, ADDR_INDIRECT_READ_PAGE, 32'hFD, 1'h0);
      xfer(1'h1, ADDR_INDIRECT_WRITE_PAGE, 32'h3, 1'h0);
      xfer(1'h0, ADDR_INDIRECT_READ_PAGE, 32'h5, 1'h0);
      xfer(1'h0, ADDR_INDIRECT_WRITE_PAGE, 32'h3, 1'h0);
      // ptr, then store, then load, all from current page 2
      for (int i = 0; i < 3; i++) begin
         core_u.move(srp_mvi_s'(3'(1 << i)), 3'h2);
         @(negedge sys_clk);
         chk("sram_page", pg[i], 32'(sram_page));
      end
   endtask
   task automatic t_bank();
      @(posedge sys_clk);
      flash_ofs <= 13'h123;
      xfer(1'h1, ADDR_FLASH_BANK_SELECT, 32'hFE, 1'h0);
      xfer(1'h0, ADDR_FLASH_BANK_SELECT, 32'h2, 1'h0);
      repeat (2) @(negedge sys_clk);
      chk("flash_addr", {17'h0, 2'h2, 13'h123}, 32'(flash_addr));
      chk("cal_table_bank", 32'h0, 32'(cal_table_bank));
   endtask
   task automatic t_scr();
      do_reset();
      xfer(1'h1, ADDR_SYSTEM_STATUS_CONTROL, 32'h0, 1'h0);
      xfer(1'h1, ADDR_SYSTEM_STATUS_CONTROL, 32'hFF, 1'h0);
      xfer(1'h0, ADDR_SYSTEM_STATUS_CONTROL, 32'h19, 1'h0);
      xtal_switch_req <= 1'h1;
      repeat (3) @(negedge sys_clk);
      chk("slow_clk_xtal", 32'h0, 32'(slow_clk_xtal));
      chk("ram_clear_min", 32'h1, 32'(ram_clear_min));
      chk("imo_slow", 32'h1, 32'(imo_slow));
      chk("system_clock_slow", 32'h1, 32'(system_clock_slow));
      @(posedge sys_clk);
      ext_clock_pin <= 1'h1;
      repeat (5) @(negedge sys_clk);
      chk("system_clock_slow", 32'h0, 32'(system_clock_slow));
      @(posedge sys_clk);
      do_reset();
      xfer(1'h1, ADDR_SYSTEM_STATUS_CONTROL, 32'h4, 1'h0);
      xfer(1'h1, ADDR_SYSTEM_STATUS_CONTROL, 32'h0, 1'h0);
      xfer(1'h0, ADDR_SYSTEM_STATUS_CONTROL, 32'hC, 1'h0);
      repeat (3) @(negedge sys_clk);
      chk("slow_clk_xtal", 32'h1, 32'(slow_clk_xtal));
      chk("ram_clear_min", 32'h0, 32'(ram_clear_min));
   endtask

   initial begin
      do_reset();
      t_reset();
      t_boot();
      t_pages();
      t_bank();
      t_scr();
      close_out();
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      error_cnt++;
      close_out();
   end
endmodule
`default_nettype wire
